// ===== plc_fsk_pkg.sv
// Purpose: shared constants for the power-line FSK modem control block
// Assumes: 100 MHz system clock, 32-bit APB register access
// Notes:   phase increments are derived here from the frequencies in hertz
package plc_fsk_pkg;
    // clock and synthesis rates
    localparam longint SYS_HZ      = 100_000_000;
    localparam longint MCLK_HZ     = 11_059_200;
    localparam longint TONE0_HZ    = 133_050;
    localparam longint TONE1_HZ    = 131_850;
    localparam longint CARRIER_HZ  = 132_450;
    localparam longint IF_HZ       = 5_400;
    localparam longint LO_HZ       = CARRIER_HZ - IF_HZ;
    localparam longint BIT_RATE    = 1_200;
    localparam int     ACC_W       = 32;

    // accumulator increments, 2^32 * f_out / f_in
    localparam logic [31:0] MCLK_INC  = 32'((MCLK_HZ << 32) / SYS_HZ);
    localparam logic [31:0] TONE0_INC = 32'((TONE0_HZ << 32) / MCLK_HZ);
    localparam logic [31:0] TONE1_INC = 32'((TONE1_HZ << 32) / MCLK_HZ);
    localparam logic [31:0] LO_INC    = 32'((LO_HZ << 32) / MCLK_HZ);
    localparam logic [31:0] BIT_INC   = 32'((BIT_RATE << 32) / MCLK_HZ);

    // watchdog timing
    localparam longint WDOG_MS      = 1_500;
    localparam longint HRST_US      = 1_000;
    localparam int     WDOG_W       = 28;
    localparam int     WDOG_CYCLES  = int'(WDOG_MS * SYS_HZ / 1_000);
    localparam int     HRST_CYCLES  = int'(HRST_US * SYS_HZ / 1_000_000);

    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] TXDATA_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    // field positions
    localparam int CTRL_USE_BUF  = 0;
    localparam int ST_TX_ACTIVE  = 0;
    localparam int ST_CARRIER    = 1;
    localparam int ST_HOST_RST   = 2;
    localparam int ST_LEVEL      = 3;
    localparam int ST_TX_BIT     = 5;
    localparam int ST_TEST       = 6;

    // reset values and buffer depth
    localparam logic CTRL_USE_BUF_RST = 1'b0;
    localparam int   BUF_DEPTH        = 2;
endpackage : plc_fsk_pkg

// ===== plc_phase_acc.sv
// Purpose: phase accumulator giving a square wave and a wrap pulse
// Assumes: en is a one-cycle enable, inc is stable while in use
// Notes:   square wave is the accumulator msb, wrap pulse is registered
`timescale 1ns/1ps
`default_nettype none
module plc_phase_acc #(
    parameter int W = 32
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         en,
    input  wire logic [W-1:0] inc,
    output logic              wrap,
    output logic              square
);
    typedef struct packed {
        logic [W-1:0] acc;
        logic         wrap;
    } plc_acc_t;

    plc_acc_t st;
    plc_acc_t next_st;
    logic [W:0] sum;

    // advance phase on each enable
    always_comb begin
        next_st  = st;
        sum      = {1'b0, st.acc} + {1'b0, inc};
        next_st.wrap = 1'b0;
        if (en) begin
            next_st.acc  = sum[W-1:0];
            next_st.wrap = sum[W];
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wrap   = st.wrap;
    assign square = st.acc[W-1];
endmodule : plc_phase_acc
`default_nettype wire

// ===== plc_fsk_ctrl.sv
// Purpose: digital control of a half-duplex power-line FSK modem
// Assumes: pins synchronous to sys_clk, APB register access
// Notes:   tones are square waves for the analog filter stages
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module plc_fsk_ctrl
    import plc_fsk_pkg::*;
#(
    parameter int WDOG_TIMEOUT = WDOG_CYCLES,
    parameter int HRST_WIDTH   = HRST_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_request_in,
    input  wire logic        tx_data_in,
    input  wire logic        carrier_detect_in,
    input  wire logic        watchdog_in,
    input  wire logic        continuous_tx_test_sel,
    input  wire logic        test_mode_sel_b,
    input  wire logic        test_mode_sel_c,
    input  wire logic        test_mode_sel_d,
    output logic             tx_analog_out,
    output logic             rx_lo_out,
    output logic             line_driver_enable,
    output logic             carrier_present,
    output logic             host_reset_out
);
    typedef struct packed {
        logic [BUF_DEPTH-1:0] mem;
        logic                 wrPtr;
        logic                 rdPtr;
        logic [1:0]           level;
        logic                 txBit;
        logic                 useBuf;
        logic                 txActive;
        logic                 rxActive;
        logic                 carrier;
        logic [3:0]           testQ;
        logic                 wdPrev;
        logic [WDOG_W-1:0]    wdCnt;
        logic [WDOG_W-1:0]    rstCnt;
        logic                 hostRst;
        logic [31:0]          rdData;
        logic                 slvErr;
    } plc_state_t;

    plc_state_t st;
    plc_state_t next_st;

    logic mTick;
    logic bitTick;
    logic toneSq;
    logic loSq;
    logic txBitEff;
    logic txWant;
    logic [31:0] toneInc;
    logic setup;
    logic access;
    logic mapped;
    logic bufFull;
    logic push;
    logic pop;
    logic wdFall;
    logic wdExpire;

    // master clock enable and the rates divided from it
    plc_phase_acc #(.W(ACC_W)) u_mclk (.sys_clk(sys_clk), .rst(rst), .en(1'b1),
        .inc(MCLK_INC), .wrap(mTick), .square());
    plc_phase_acc #(.W(ACC_W)) u_bit (.sys_clk(sys_clk), .rst(rst), .en(mTick),
        .inc(BIT_INC), .wrap(bitTick), .square());
    plc_phase_acc #(.W(ACC_W)) u_tone (.sys_clk(sys_clk), .rst(rst),
        .en(mTick & st.txActive), .inc(toneInc), .wrap(), .square(toneSq));
    plc_phase_acc #(.W(ACC_W)) u_lo (.sys_clk(sys_clk), .rst(rst),
        .en(mTick & st.rxActive), .inc(LO_INC), .wrap(), .square(loSq));

    // bit source: direct pin or paced buffer; test b/c force a tone
    always_comb begin
        txBitEff = st.useBuf ? st.txBit : tx_data_in;
        if (st.testQ[1]) begin
            txBitEff = 1'b0;
        end else if (st.testQ[2]) begin
            txBitEff = 1'b1;
        end
        toneInc = txBitEff ? TONE1_INC : TONE0_INC;
    end

    // apb decode and buffer handshake
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign mapped  = (paddr == CTRL_OFS) || (paddr == TXDATA_OFS) || (paddr == STATUS_OFS);
    assign bufFull = (st.level == 2'(BUF_DEPTH));
    assign pready  = ~(access & pwrite & (paddr == TXDATA_OFS) & bufFull);
    assign push    = access & pwrite & (paddr == TXDATA_OFS) & ~bufFull;
    assign pop     = bitTick & st.useBuf & st.txActive & ~st.testQ[3]
                     & (st.level != 2'd0);
    assign txWant  = tx_request_in | continuous_tx_test_sel;
    assign wdFall  = st.wdPrev & ~watchdog_in;
    assign wdExpire = ~wdFall && (st.wdCnt == WDOG_W'(WDOG_TIMEOUT - 1));

    // next-state logic
    always_comb begin
        next_st        = st;
        next_st.testQ  = {test_mode_sel_d, test_mode_sel_c, test_mode_sel_b,
                          continuous_tx_test_sel};
        next_st.carrier  = carrier_detect_in;
        next_st.txActive = txWant;
        next_st.rxActive = ~txWant;
        next_st.wdPrev   = watchdog_in;
        // register writes
        if (access && pwrite && (paddr == CTRL_OFS)) begin
            next_st.useBuf = pwdata[CTRL_USE_BUF];
        end
        // two-entry transmit bit buffer
        if (push) begin
            next_st.mem[st.wrPtr] = pwdata[0];
            next_st.wrPtr = ~st.wrPtr;
        end
        if (pop) begin
            next_st.txBit = st.mem[st.rdPtr];
            next_st.rdPtr = ~st.rdPtr;
        end
        next_st.level = st.level + 2'(push) - 2'(pop);
        // read data captured in setup, answered in access
        if (setup) begin
            next_st.slvErr = ~mapped;
            next_st.rdData = '0;
            case (paddr)
                CTRL_OFS: begin
                    next_st.rdData[CTRL_USE_BUF] = st.useBuf;
                end
                STATUS_OFS: begin
                    next_st.rdData[ST_TX_ACTIVE] = st.txActive;
                    next_st.rdData[ST_CARRIER]   = st.carrier;
                    next_st.rdData[ST_HOST_RST]  = st.hostRst;
                    next_st.rdData[ST_LEVEL+:2]  = st.level;
                    next_st.rdData[ST_TX_BIT]    = txBitEff;
                    next_st.rdData[ST_TEST+:4]   = st.testQ;
                end
                default: begin
                    next_st.rdData = '0;
                end
            endcase
        end
        // host reset pulse length, ahead of expiry so a fresh expiry wins
        if (st.hostRst) begin
            next_st.rstCnt = st.rstCnt + 1'b1;
            if (st.rstCnt == WDOG_W'(HRST_WIDTH - 1)) begin
                next_st.hostRst = 1'b0;
            end
        end
        // watchdog timeout and host reset start
        if (wdFall) begin
            next_st.wdCnt = '0;
        end else if (wdExpire) begin
            next_st.wdCnt   = '0;
            next_st.hostRst = 1'b1;
            next_st.rstCnt  = '0;
        end else begin
            next_st.wdCnt = st.wdCnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st        <= '0;
            st.useBuf <= CTRL_USE_BUF_RST;
            st.rxActive <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign prdata             = st.rdData;
    assign pslverr            = st.slvErr;
    assign line_driver_enable = st.txActive;
    assign tx_analog_out      = st.txActive & toneSq;
    assign rx_lo_out          = st.rxActive & loSq;
    assign carrier_present    = st.carrier;
    assign host_reset_out     = st.hostRst;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_expire;
        wdExpire && !st.hostRst;
    endsequence
    sequence s_rst_pulse;
        host_reset_out ##1 host_reset_out;
    endsequence

    a_half_duplex: assert property (!(st.txActive && st.rxActive))
        else $error("transmit and receive active together");
    a_ldrv_follow: assert property (1 |=> line_driver_enable == $past(txWant))
        else $error("line driver enable not tracking transmit mode");
    a_cont_tx: assert property (continuous_tx_test_sel |=> line_driver_enable)
        else $error("continuous transmit test not transmitting");
    a_mode_cause: assert property ($changed(line_driver_enable) |->
        $past(tx_request_in) != $past(tx_request_in, 2)
        || $past(continuous_tx_test_sel) != $past(continuous_tx_test_sel, 2))
        else $error("mode changed without request change");
    a_wdog_restart: assert property (wdFall |=> st.wdCnt == '0)
        else $error("watchdog not restarted by falling edge");
    a_wdog_expire: assert property (s_expire |=> s_rst_pulse)
        else $error("host reset missing after timeout");
    a_bit_pop: assert property (pop |=> st.txBit == $past(st.mem[st.rdPtr]))
        else $error("buffered bit not presented");
    a_mclk_rate: assert property (mTick |=> !mTick)
        else $error("master enable faster than half clock");
    a_tone_zero: assert property (st.txActive && (st.testQ[1]
        || (!st.testQ[2] && !st.useBuf && !tx_data_in)) |-> toneInc == TONE0_INC)
        else $error("wrong tone for zero bit");
    a_test_seen: assert property (test_mode_sel_b |=> st.testQ[1] && !txBitEff)
        else $error("test select b not applied");
endmodule : plc_fsk_ctrl
`default_nettype wire

// ===== plc_host_model.sv
// Purpose: host model, drives transmit request and watchdog pulses
// Assumes: sys_clk always runs
// Notes:   request is raised only while no carrier is seen
`timescale 1ns/1ps
`default_nettype none
module plc_host_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic carrierPresent,
    input  wire logic wantTx,
    input  wire logic kickEn,
    output logic      txRequest,
    output logic      watchdogPulse
);
    logic [5:0] tick;
    // defer while carrier seen, kick watchdog every 64 cycles
    always_ff @(posedge sys_clk) begin
        tick <= rst ? 6'h00 : tick + 6'h01;
        txRequest <= !rst && wantTx && (txRequest || !carrierPresent);
        watchdogPulse <= kickEn && tick[5];
    end
endmodule : plc_host_model
`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench for the modem control block
// Assumes: shortened watchdog counts
// Notes:   buffer drain waits up to one real bit period
`timescale 1ns/1ps
`default_nettype none
module tb;
    import plc_fsk_pkg::*;
    localparam int WD = 200;
    localparam int HW = 10;
    logic        sysClk, rst, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        txData, carrier, cont, selB, selC, selD, wantTx, kickEn;
    logic        txReq, wdog, tone, lo, lde, carrierPresent, hostRst;
    int          errCount, checks, w;
    // clock always supplied
    initial begin
        sysClk = 1'b0;
        forever #5 sysClk = ~sysClk;
    end
    plc_fsk_ctrl #(.WDOG_TIMEOUT(WD), .HRST_WIDTH(HW)) i_dut (
        .sys_clk(sysClk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_request_in(txReq),
        .tx_data_in(txData), .carrier_detect_in(carrier), .watchdog_in(wdog),
        .continuous_tx_test_sel(cont), .test_mode_sel_b(selB),
        .test_mode_sel_c(selC), .test_mode_sel_d(selD), .tx_analog_out(tone),
        .rx_lo_out(lo), .line_driver_enable(lde),
        .carrier_present(carrierPresent), .host_reset_out(hostRst));
    plc_host_model i_host (.sys_clk(sysClk), .rst(rst),
        .carrierPresent(carrierPresent), .wantTx(wantTx), .kickEn(kickEn),
        .txRequest(txReq), .watchdogPulse(wdog));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", checks, errCount);
        if (errCount == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    // a spent bound counts as a mismatch and ends the run
    task automatic expire(input bit spent);
        if (spent) begin
            errCount++;
            conclude();
        end
    endtask : expire
    // one apb transfer, answer taken at the pready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sysClk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge sysClk);
        penable <= 1'b1;
        do begin
            @(posedge sysClk);
            n++;
        end while (pready !== 1'b1 && n < 90000);
        expire(pready !== 1'b1);
        w = n - 1;
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic tRegs;
        apb(1'b0, CTRL_OFS, 32'h0);
        check(q, 32'h0);
        apb(1'b1, CTRL_OFS, 32'hFFFFFFFF);
        check(32'(w), 32'h0);
        apb(1'b0, CTRL_OFS, 32'h0);
        check(q, 32'h1);
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check({q[30:0], e}, 32'h1);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(q, 32'h0);
        $display("register test done");
    endtask : tRegs
    task automatic tMode;
        int c, t;
        c = 0;
        t = 0;
        @(posedge sysClk);
        carrier <= 1'b1;
        @(posedge sysClk);
        wantTx <= 1'b1;
        repeat (1000) @(negedge sysClk) c += (lo === 1'b1) ? 1 : 0;
        check(32'(lde), 32'h0);
        check(32'(carrierPresent), 32'h1);
        check(32'(c > 300), 32'h1);
        @(posedge sysClk);
        carrier <= 1'b0;
        repeat (4) @(negedge sysClk);
        check(32'(lde), 32'h1);
        c = 0;
        repeat (1000) @(negedge sysClk) {c, t} = {c + int'(lo), t + int'(tone)};
        check(32'(c == 0 && t > 300), 32'h1);
        @(posedge sysClk);
        wantTx <= 1'b0;
        repeat (3) @(negedge sysClk);
        check(32'({lde, tone}), 32'h0);
        $display("mode test done");
    endtask : tMode
    task automatic tTone;
        int c, n;
        logic last;
        for (int b = 0; b < 2; b++) begin
            @(posedge sysClk);
            {txData, wantTx} <= {b[0], 1'b1};
            repeat (900) @(negedge sysClk);
            apb(1'b0, STATUS_OFS, 32'h0);
            check(32'(q[ST_TX_BIT]), 32'(b));
            {n, c, last} = {32'd0, 32'd0, 1'b1};
            for (int k = 0; k < 20000 && n < 11; k++) begin
                @(negedge sysClk);
                if (tone === 1'b1 && !last) n++;
                if (n > 0) c++;
                last = tone;
            end
            expire(n < 11);
            c = c - int'(10 * SYS_HZ / (b ? TONE1_HZ : TONE0_HZ));
            check(32'(c < 20 && c > -20), 32'h1);
        end
        @(posedge sysClk);
        wantTx <= 1'b0;
        $display("tone test done");
    endtask : tTone
    task automatic tTest;
        logic [3:0] m;
        for (int i = 0; i < 4; i++) begin
            m = 4'h1 << i;
            @(posedge sysClk);
            {selD, selC, selB, cont, txData} <= {m, i == 1};
            repeat (3) @(negedge sysClk);
            apb(1'b0, STATUS_OFS, 32'h0);
            check(32'(q[9:6]), 32'(m));
            check(32'(lde), 32'(i == 0));
            if (i == 1 || i == 2) check(32'(q[ST_TX_BIT]), 32'(i == 2));
        end
        @(posedge sysClk);
        selD <= 1'b0;
        $display("test select test done");
    endtask : tTest
    task automatic tWdog;
        int c;
        logic p;
        {p, c} = {1'b0, 32'd0};
        while (!(p && wdog === 1'b0) && c < 500) begin
            p = wdog;
            @(negedge sysClk);
            c++;
        end
        expire(!(p && wdog === 1'b0));
        check(32'(hostRst), 32'h0);
        @(posedge sysClk);
        kickEn <= 1'b0;
        c = 0;
        while (hostRst !== 1'b1 && c < 1000) @(negedge sysClk) c++;
        expire(hostRst !== 1'b1);
        check(32'(c >= WD - 1 && c <= WD + 3), 32'h1);
        c = 0;
        while (hostRst === 1'b1 && c < 100) @(negedge sysClk) c++;
        expire(hostRst === 1'b1);
        check(32'(c), 32'(HW));
        @(posedge sysClk);
        kickEn <= 1'b1;
        $display("watchdog test done");
    endtask : tWdog
    task automatic tBuf;
        @(posedge sysClk);
        {selD, wantTx} <= 2'b11;
        apb(1'b1, CTRL_OFS, 32'h1);
        apb(1'b1, TXDATA_OFS, 32'h1);
        apb(1'b1, TXDATA_OFS, 32'h0);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(32'(q[4:3]), 32'h2);
        @(posedge sysClk);
        selD <= 1'b0;
        apb(1'b1, TXDATA_OFS, 32'h1); // held off until a bit is sent
        check(32'(w > 100), 32'h1);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(32'(q[4:3]), 32'h2);
        check(32'(q[ST_TX_BIT]), 32'h1);
        $display("buffer test done");
    endtask : tBuf
    // reset, then the scenarios in turn
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} <= {4'h8, 8'h00, 32'h0};
        {txData, carrier, cont, selB, selC, selD, wantTx, kickEn} <= 8'h01;
        {errCount, checks} = {32'd0, 32'd0};
        repeat (2) @(posedge sysClk);
        rst <= 1'b0;
        tRegs();
        tMode();
        tTone();
        tTest();
        tWdog();
        tBuf();
        conclude();
    end
endmodule : tb
`default_nettype wire
